// file: shared/sbit_pkg.sv
// sbit_pkg: constants, field layouts and types of the 16-bit interval timer.
// assumes: imported by nobody; every use is written sbit_pkg::name.
`default_nettype none

package sbit_pkg;

  // ----------------------------------------------------------------
  // register map (word index on the plain register port)
  // ----------------------------------------------------------------
  localparam int unsigned SBIT_ADDR_W = 3;
  localparam int unsigned SBIT_DATA_W = 16;
  localparam logic [2:0] SBIT_OFS_CTRL = 3'h0;
  localparam logic [2:0] SBIT_OFS_COUNT = 3'h1;
  localparam logic [2:0] SBIT_OFS_PERIOD = 3'h2;
  localparam logic [2:0] SBIT_OFS_STATUS = 3'h3;
  localparam logic [2:0] SBIT_OFS_MASK = 3'h4;
  localparam logic [2:0] SBIT_OFS_INTCTL = 3'h5;

  // ----------------------------------------------------------------
  // reset values and writable bits
  // ----------------------------------------------------------------
  localparam logic [15:0] SBIT_CTRL_RST = 16'h0000;
  localparam logic [15:0] SBIT_CTRL_WMASK = 16'ha076;
  localparam logic [15:0] SBIT_COUNT_RST = 16'h0000;
  localparam logic [15:0] SBIT_PERIOD_RST = 16'hffff;
  localparam logic [1:0] SBIT_STATUS_RST = 2'h0;
  localparam logic [1:0] SBIT_MASK_RST = 2'h0;
  localparam logic [2:0] SBIT_PRIO_RST = 3'h0;

  // status / mask bit positions
  localparam int unsigned SBIT_ST_MATCH = 0;
  localparam int unsigned SBIT_ST_GATE = 1;
  localparam int unsigned SBIT_ST_W = 2;

  // interrupt control register layout
  localparam int unsigned SBIT_IC_EN_BIT = 0;
  localparam int unsigned SBIT_IC_PRIO_LSB = 4;
  localparam int unsigned SBIT_PRIO_W = 3;

  // prescaler counter width and terminal counts
  localparam int unsigned SBIT_PS_W = 8;
  localparam logic [7:0] SBIT_PS_LAST_1 = 8'h00;
  localparam logic [7:0] SBIT_PS_LAST_8 = 8'h07;
  localparam logic [7:0] SBIT_PS_LAST_64 = 8'h3f;
  localparam logic [7:0] SBIT_PS_LAST_256 = 8'hff;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SBIT_DIV1 = 2'h0,
    SBIT_DIV8 = 2'h1,
    SBIT_DIV64 = 2'h2,
    SBIT_DIV256 = 2'h3
  } sbit_prescale_t;

  // control register, msb first
  typedef struct packed {
    logic run_control;
    logic rsv14;
    logic idle_halt_select;
    logic [5:0] rsv12_7;
    logic gate_accumulate_enable;
    sbit_prescale_t prescale_select;
    logic rsv3;
    logic ext_clock_sync_select;
    logic clock_source_select;
    logic rsv0;
  } sbit_ctrl_t;

  typedef struct packed {
    logic gate_fall;
    logic match;
  } sbit_status_t;

  // terminal count of the prescaler for a ratio select
  function automatic logic [7:0] sbit_ps_last(input sbit_prescale_t sel);
    case (sel)
      SBIT_DIV1: sbit_ps_last = SBIT_PS_LAST_1;
      SBIT_DIV8: sbit_ps_last = SBIT_PS_LAST_8;
      SBIT_DIV64: sbit_ps_last = SBIT_PS_LAST_64;
      default: sbit_ps_last = SBIT_PS_LAST_256;
    endcase
  endfunction

endpackage

`default_nettype wire

// file: verilog/sbit_prescale.sv
// sbit_prescale: input clock prescaler, divides a tick stream by 1/8/64/256.
// assumes: i_tick is a one-cycle qualified count pulse in the i_clk domain.
`timescale 1ns/10ps
`default_nettype none

module sbit_prescale #(
  parameter int unsigned CNT_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clear,
  input wire logic i_tick,
  input wire sbit_pkg::sbit_prescale_t i_sel,
  output logic o_tick
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] last;

  // ------------------------------------------------------------
  // ratio decode
  // ------------------------------------------------------------
  assign last = CNT_W'(sbit_pkg::sbit_ps_last(i_sel));
  // clear takes priority so a control write restarts the ratio cleanly
  assign o_tick = i_tick && !i_clear && (cnt_r >= last);

  // ------------------------------------------------------------
  // divider counter
  // ------------------------------------------------------------
  // >= guards a ratio lowered mid-count from wrapping through 256
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
    end else if (i_clear) begin
      cnt_r <= '0;
    end else if (i_tick) begin
      if (cnt_r >= last) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end
  end

endmodule // sbit_prescale

`default_nettype wire

// file: verilog/sbit_timer.sv
// sbit_timer: 16-bit interval timer / counter with gate, prescaler and
// period-match interrupt, reached over a plain register port.
// assumes: one clock i_clk (200 MHz), synchronous active-low reset, pin
// inputs i_ext_clock_pin and i_gate sampled on i_clk, idle/sleep as levels.
//
// How it works
// - one 16-bit timer, sync or async counter
// - interrupt on period match or gate fall
// - control bit 15 starts and stops counting
// - control bit 13 halts counting in idle
// - bit 6 gates only with internal clock
// - bits 5-4 select 1, 8, 64, 256
// - bit 2 synchronises external clock when selected
// - bit 1 picks external pin or internal
// - control write while running clears prescaler
// - interrupt needs enable bit, carries priority
// - keeps running through idle unless bit 13 set; in sleep only on the unsynchronised external clock
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none

module sbit_timer #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [sbit_pkg::SBIT_ADDR_W-1:0] i_addr,
  input wire logic [sbit_pkg::SBIT_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [sbit_pkg::SBIT_DATA_W-1:0] o_rdata,
  input wire logic i_ext_clock_pin,
  input wire logic i_gate,
  input wire logic i_idle,
  input wire logic i_sleep,
  output logic o_irq,
  output logic [sbit_pkg::SBIT_PRIO_W-1:0] o_irq_priority
);

  // ------------------------------------------------------------
  // registers and state
  // ------------------------------------------------------------
  sbit_pkg::sbit_ctrl_t timer_control_r;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] period_register_r;
  sbit_pkg::sbit_status_t status_r;
  sbit_pkg::sbit_status_t status_nxt;
  sbit_pkg::sbit_status_t mask_r;
  logic interrupt_enable_bit_r;
  logic [sbit_pkg::SBIT_PRIO_W-1:0] interrupt_priority_field_r;

  // pin sampling
  logic ext_meta_r;
  logic ext_sync_r;
  logic ext_sync_d_r;
  logic ext_raw_d_r;
  logic gate_meta_r;
  logic gate_sync_r;
  logic gate_sync_d_r;

  // decoded strobes and control terms
  logic wr_ctrl;
  logic wr_count;
  logic wr_period;
  logic wr_status;
  logic wr_mask;
  logic wr_intctl;
  logic ext_src;
  logic gated_mode;
  logic ext_edge;
  logic base_tick;
  logic active;
  logic ps_clear;
  logic ps_tick;
  logic period_hit;
  logic ev_match;
  logic ev_gate_fall;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  assign wr_ctrl = i_wr && (i_addr == sbit_pkg::SBIT_OFS_CTRL);
  assign wr_count = i_wr && (i_addr == sbit_pkg::SBIT_OFS_COUNT);
  assign wr_period = i_wr && (i_addr == sbit_pkg::SBIT_OFS_PERIOD);
  assign wr_status = i_wr && (i_addr == sbit_pkg::SBIT_OFS_STATUS);
  assign wr_mask = i_wr && (i_addr == sbit_pkg::SBIT_OFS_MASK);
  assign wr_intctl = i_wr && (i_addr == sbit_pkg::SBIT_OFS_INTCTL);

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  // reserved bits are forced to zero so they always read back as zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      timer_control_r <= sbit_pkg::SBIT_CTRL_RST;
    end else if (wr_ctrl) begin
      timer_control_r <= i_wdata & sbit_pkg::SBIT_CTRL_WMASK;
    end
  end

  // period register
  // period loaded by software
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      period_register_r <= CNT_W'(sbit_pkg::SBIT_PERIOD_RST);
    end else if (wr_period) begin
      period_register_r <= CNT_W'(i_wdata);
    end
  end

  // interrupt mask and interrupt control
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mask_r <= sbit_pkg::SBIT_MASK_RST;
    end else if (wr_mask) begin
      mask_r <= i_wdata[sbit_pkg::SBIT_ST_W-1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      interrupt_enable_bit_r <= 1'b0;
      interrupt_priority_field_r <= sbit_pkg::SBIT_PRIO_RST;
    end else if (wr_intctl) begin
      interrupt_enable_bit_r <= i_wdata[sbit_pkg::SBIT_IC_EN_BIT];
      interrupt_priority_field_r <=
        i_wdata[sbit_pkg::SBIT_IC_PRIO_LSB +: sbit_pkg::SBIT_PRIO_W];
    end
  end

  // ------------------------------------------------------------
  // pin sampling
  // ------------------------------------------------------------
  // two-flop synchroniser; the meta flop feeds only the second flop
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      ext_sync_d_r <= 1'b0;
    end else begin
      ext_meta_r <= i_ext_clock_pin;
      ext_sync_r <= ext_meta_r;
      ext_sync_d_r <= ext_sync_r;
    end
  end

  // unsynchronised path: two cycles less latency, no metastability filter
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ext_raw_d_r <= 1'b0;
    end else begin
      ext_raw_d_r <= i_ext_clock_pin;
    end
  end

  // gate input always synchronised, it also sources an interrupt
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      gate_meta_r <= 1'b0;
      gate_sync_r <= 1'b0;
      gate_sync_d_r <= 1'b0;
    end else begin
      gate_meta_r <= i_gate;
      gate_sync_r <= gate_meta_r;
      gate_sync_d_r <= gate_sync_r;
    end
  end

  // ------------------------------------------------------------
  // clock source, gating and run qualification
  // ------------------------------------------------------------
  // source select
  assign ext_src = timer_control_r.clock_source_select;
  assign gated_mode = timer_control_r.gate_accumulate_enable && !ext_src;
  assign ext_edge = timer_control_r.ext_clock_sync_select ?
                    (ext_sync_r && !ext_sync_d_r) :
                    (i_ext_clock_pin && !ext_raw_d_r);

  always_comb begin
    if (ext_src) begin
      base_tick = ext_edge;
    end else if (gated_mode) begin
      base_tick = gate_sync_r;
    end else begin
      base_tick = 1'b1;
    end
  end

  // idle/sleep otherwise keep counting
  // sleep stops the system clock, so only the raw external path survives
  always_comb begin
    active = timer_control_r.run_control;
    if (i_idle && timer_control_r.idle_halt_select) begin
      active = 1'b0;
    end
    if (i_sleep && !(ext_src && !timer_control_r.ext_clock_sync_select)) begin
      active = 1'b0;
    end
  end

  assign ps_clear = !timer_control_r.run_control ||
                    (wr_ctrl && timer_control_r.run_control);

  sbit_prescale #(
    .CNT_W(sbit_pkg::SBIT_PS_W)
  ) u_prescale (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clear(ps_clear),
    .i_tick(active && base_tick),
    .i_sel(timer_control_r.prescale_select),
    .o_tick(ps_tick)
  );

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  assign period_hit = (count_r == period_register_r);

  // wrap to zero on match
  // a software write to the count wins over a tick in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      count_r <= CNT_W'(sbit_pkg::SBIT_COUNT_RST);
    end else if (wr_count) begin
      count_r <= CNT_W'(i_wdata);
    end else if (ps_tick) begin
      if (period_hit) begin
        count_r <= '0;
      end else begin
        count_r <= count_r + CNT_W'(1);
      end
    end
  end

  // ------------------------------------------------------------
  // events and sticky status
  // ------------------------------------------------------------
  // match outside gated mode
  assign ev_match = ps_tick && period_hit && !gated_mode;
  // gate falling edge in gated mode
  assign ev_gate_fall = gated_mode && active && gate_sync_d_r && !gate_sync_r;

  // write one to clear; an event in the clearing cycle still sets
  always_comb begin
    status_nxt = status_r;
    if (wr_status) begin
      status_nxt = status_r & ~i_wdata[sbit_pkg::SBIT_ST_W-1:0];
    end
    status_nxt.match = status_nxt.match || ev_match;
    status_nxt.gate_fall = status_nxt.gate_fall || ev_gate_fall;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      status_r <= sbit_pkg::SBIT_STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  // ------------------------------------------------------------
  // interrupt output
  // ------------------------------------------------------------
  // enable bit and priority
  // level output, follows the status one cycle later
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
      o_irq_priority <= '0;
    end else begin
      o_irq <= interrupt_enable_bit_r && |(status_r & mask_r);
      o_irq_priority <= interrupt_priority_field_r;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // read data valid only the cycle after the strobe, zero otherwise
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      case (i_addr)
        sbit_pkg::SBIT_OFS_CTRL: o_rdata <= timer_control_r;
        sbit_pkg::SBIT_OFS_COUNT: o_rdata <= 16'(count_r);
        sbit_pkg::SBIT_OFS_PERIOD: o_rdata <= 16'(period_register_r);
        sbit_pkg::SBIT_OFS_STATUS: o_rdata <= {14'h0000, status_r};
        sbit_pkg::SBIT_OFS_MASK: o_rdata <= {14'h0000, mask_r};
        sbit_pkg::SBIT_OFS_INTCTL: begin
          o_rdata <= {9'h000, interrupt_priority_field_r, 3'h0,
                      interrupt_enable_bit_r};
        end
        default: o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

endmodule // sbit_timer

`default_nettype wire

// file: tb/sbit_timer_checker.sv
// sbit_timer_checker: port assertions for the 16-bit interval timer.
// assumes: bound into sbit_timer; shadows mirror what software wrote.
`timescale 1ns/10ps
`default_nettype none

module sbit_timer_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic o_irq,
  input wire logic [2:0] o_irq_priority
);
  logic [15:0] ctrl_r;
  logic [15:0] per_r;
  logic [1:0] mask_r;
  logic en_r;
  logic [2:0] pr_r;

  // ----------------------------------------
  // write shadows
  // ----------------------------------------
  // reserved control bits never stored, so shadow keeps them zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_r <= 16'h0000;
      per_r <= 16'hffff;
      mask_r <= 2'h0;
      en_r <= 1'b0;
      pr_r <= 3'h0;
    end else if (i_wr) begin
      if (i_addr == 3'h0) ctrl_r <= i_wdata & 16'ha076;
      if (i_addr == 3'h2) per_r <= i_wdata;
      if (i_addr == 3'h4) mask_r <= i_wdata[1:0];
      if (i_addr == 3'h5) en_r <= i_wdata[0];
      if (i_addr == 3'h5) pr_r <= i_wdata[6:4];
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  a_ctrl_readback: assert property ($past(i_rd) && $past(i_addr) == 3'h0
    |-> o_rdata == $past(ctrl_r)) else $error("control readback wrong");
  a_period_readback: assert property ($past(i_rd) && $past(i_addr) == 3'h2
    |-> o_rdata == $past(per_r)) else $error("period readback wrong");
  a_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) > 3'h5
    |-> o_rdata == 16'h0000) else $error("unmapped read not zero");
  a_status_upper: assert property ($past(i_rd) && $past(i_addr) == 3'h3
    |-> o_rdata[15:2] == 14'h0000) else $error("status upper bits set");
  a_intctl_readback: assert property ($past(i_rd) && $past(i_addr) == 3'h5
    |-> o_rdata == {9'h000, $past(pr_r), 3'h0, $past(en_r)})
    else $error("interrupt control readback wrong");
  a_irq_needs_en: assert property (o_irq |-> en_r || $past(en_r))
    else $error("interrupt high while disabled");
  a_irq_needs_mask: assert property (o_irq |-> (|mask_r) || (|$past(mask_r)))
    else $error("interrupt high with all sources masked");
  a_prio_copy: assert property (o_irq_priority == $past(pr_r))
    else $error("priority output does not follow field");

  // main scenarios reached
  c_irq_rise: cover property ($rose(o_irq));
  c_ctrl_read: cover property ($past(i_rd) && $past(i_addr) == 3'h0);
  c_unmapped_read: cover property (i_rd && i_addr > 3'h5);
endmodule // sbit_timer_checker

bind sbit_timer sbit_timer_checker i_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
  .o_irq_priority(o_irq_priority));

`default_nettype wire

// file: tb/sbit_pin_src.sv
// sbit_pin_src: far-side source of the count clock pin and the gate pin.
// assumes: bench calls its tasks; pins change just after i_clk rises.
`timescale 1ns/10ps
`default_nettype none

module sbit_pin_src (
  input wire logic i_clk,
  output logic o_ext_clock_pin,
  output logic o_gate
);
  // ----------------------------------------
  // pin stimulus
  // ----------------------------------------
  // clock pin rests low between bursts, so no stray edge is counted
  initial begin
    o_ext_clock_pin = 1'b0;
    o_gate = 1'b0;
  end

  // burst of n rising edges, half period in clocks
  task automatic pulses(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge i_clk);
      o_ext_clock_pin <= 1'b1;
      repeat (half) @(posedge i_clk);
      o_ext_clock_pin <= 1'b0;
    end
  endtask

  // gate held as a level until changed
  task automatic gate_set(input logic lvl);
    @(posedge i_clk);
    o_gate <= lvl;
  endtask
endmodule // sbit_pin_src

`default_nettype wire

// file: tb/testbench.sv
// testbench: self-checking bench for the 16-bit interval timer.
// assumes: sbit_pin_src drives both pins; 200 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic clk, rst_n, wr, rd, idle, sleep, irq, pin, gate;
  logic [2:0] addr, prio;
  logic [15:0] wdata, rdata, v, c;
  int mismatches, checked;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  sbit_timer i_sbit_timer (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ext_clock_pin(pin), .i_gate(gate),
    .i_idle(idle), .i_sleep(sleep), .o_irq(irq), .o_irq_priority(prio));
  sbit_pin_src i_sbit_pin_src (.i_clk(clk), .o_ext_clock_pin(pin), .o_gate(gate));

  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic wr16(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd16(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // latency of stopping the timer is loose, so counts taken while it runs get a window
  task automatic chk_rng(input string n, input logic [15:0] lo, hi, g);
    checked++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      mismatches++;
      $display("mismatch %s expected %h..%h seen %h", n, lo, hi, g);
    end
  endtask
  task automatic rc(input logic [2:0] a, input logic [15:0] e, input string n);
    rd16(a, v);
    chk(n, e, v);
  endtask
  task automatic arm(input logic [15:0] ctl);
    wr16(3'h0, 16'h0000);
    wr16(3'h1, 16'h0000);
    wr16(3'h0, ctl);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // reset values and reserved bits
  task automatic t_regs();
    logic [15:0] e [8] = '{2: 16'hffff, default: 16'h0000};
    for (int a = 0; a < 8; a++) rc(3'(a), e[a], "reset value");
    wr16(3'h0, 16'hffff);
    rc(3'h0, 16'ha076, "control bits");
    wr16(3'h0, 16'h0000);
    wr16(3'h6, 16'hffff);
    rc(3'h6, 16'h0000, "unmapped");
  endtask
  task automatic t_interval();
    int n;
    wr16(3'h3, 16'h0003);
    wr16(3'h2, 16'h0002);
    wr16(3'h4, 16'h0001);
    wr16(3'h5, 16'h0051);
    arm(16'h8000);
    for (n = 0; n < 40 && irq !== 1'b1; n++) tick(1);
    chk("irq on match", 16'h0001, {15'h0, irq});
    chk("priority", 16'h0005, {13'h0, prio});
    wr16(3'h0, 16'h0000);
    rd16(3'h1, v);
    chk_rng("count wrap", 16'h0000, 16'h0002, v);
    rc(3'h3, 16'h0001, "match flag");
    wr16(3'h5, 16'h0050);
    tick(3);
    chk("irq disabled", 16'h0000, {15'h0, irq});
    wr16(3'h3, 16'h0001);
    rc(3'h3, 16'h0000, "flag cleared");
  endtask
  // prescale ratios and restart on write
  task automatic t_prescale();
    int dv [4] = '{1, 8, 64, 256};
    // full period from here on, a short one would wrap every later count
    wr16(3'h2, 16'hffff);
    for (int p = 0; p < 4; p++) begin
      arm(16'h8000 | (16'(p) << 4));
      tick(512);
      wr16(3'h0, 16'h0000);
      rd16(3'h1, v);
      chk_rng("prescaled", 16'(512 / dv[p] - 1), 16'(514 / dv[p] + 1), v);
    end
    arm(16'h8010);
    repeat (40) wr16(3'h0, 16'h8010);
    wr16(3'h0, 16'h0000);
    rc(3'h1, 16'h0000, "prescaler restart");
  endtask
  task automatic t_ext();
    logic [15:0] m [3] = '{16'h8002, 16'h8006, 16'h8046};
    for (int i = 0; i < 3; i++) begin
      arm(m[i]);
      i_sbit_pin_src.pulses(10, 4);
      tick(6);
      wr16(3'h0, 16'h0000);
      rc(3'h1, 16'h000a, "external edges");
    end
  endtask
  task automatic t_gated();
    wr16(3'h4, 16'h0003);
    wr16(3'h5, 16'h0001);
    arm(16'h8040);
    tick(30);
    rc(3'h1, 16'h0000, "gate low holds");
    i_sbit_pin_src.gate_set(1'b1);
    tick(19);
    i_sbit_pin_src.gate_set(1'b0);
    tick(8);
    wr16(3'h0, 16'h0000);
    rd16(3'h1, v);
    chk_rng("gated count", 16'h0013, 16'h0015, v);
    rc(3'h3, 16'h0002, "gate fall flag");
    chk("gate irq", 16'h0001, {15'h0, irq});
    wr16(3'h3, 16'h0003);
    tick(3);
    chk("irq cleared", 16'h0000, {15'h0, irq});
  endtask
  task automatic t_idle();
    @(posedge clk);
    idle <= 1'b1;
    arm(16'ha000);
    rd16(3'h1, c);
    tick(40);
    rc(3'h1, c, "idle halt");
    wr16(3'h0, 16'h8000);
    tick(40);
    rd16(3'h1, v);
    chk_rng("runs in idle", c + 16'h0028, c + 16'h002e, v);
    @(posedge clk);
    idle <= 1'b0;
    sleep <= 1'b1;
    arm(16'h8002);
    i_sbit_pin_src.pulses(5, 4);
    tick(6);
    wr16(3'h0, 16'h0000);
    rc(3'h1, 16'h0005, "counts in sleep");
    @(posedge clk);
    sleep <= 1'b0;
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 16'h0000;
    idle = 1'b0;
    sleep = 1'b0;
    mismatches = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_interval();
    t_prescale();
    t_ext();
    t_gated();
    t_idle();
    final_report();
  end

  // all scenarios need well under 6000 clocks
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    final_report();
  end
endmodule // testbench

`default_nettype wire
